//--- src/bdsr_read_port.v
// Purpose: Burst-of-four DDR SRAM port: command registering, byte-masked writes,
//          read beat launch on the selected timing pair, echo strobes.
// Assumes: Link strobes run far slower than ref_clk (125 ns period on the bench),
//          so each strobe edge is seen as a one-cycle pulse after synchronising.
// Notes:   Only a small array of flip-flops stands behind the address pins.
//
// Functional notes
// [RQ1] Read request low at a command positive rise registers address, starts read.
// [RQ2] In a write, a byte is stored only when its lane mask is low.
// [RQ3] Each lane mask is sampled on the same strobe edge as its data beat.
// [RQ4] Every read and write moves a fixed burst of four words.
// [RQ5] Controller issues a read at most every other command cycle.
// [RQ6] Toggling output timing pair launches read beats instead of command strobes.
// [RQ7] Echo strobes run continuously with edges matching the read data.
// [RQ8] Output timing pair held high makes command strobes time the read data.
// [RQ9] Command-timed first beat launches on the negative strobe 1.5 cycles on.
// [RQ10] Second beat launches on the next positive strobe, two cycles on.
// [RQ11] Third beat on following negative strobe, fourth on the positive after.
// [RQ12] A cycle with no read request never cuts a burst in progress short.
// [RQ13] Write request low at a command positive rise registers address, starts write.
// [RQ14] DLL bypass held low shortens read latency to one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "bdsr_map.vh"

module bdsr_read_port (
    input  wire                     ref_clk,
    input  wire                     rst_n,
    input  wire                     cmd_strobe_pos,
    input  wire                     cmd_strobe_neg,
    input  wire                     output_timing_pos,
    input  wire                     output_timing_neg,
    input  wire                     read_request_n,
    input  wire                     write_request_n,
    input  wire                     dll_bypass_n,
    input  wire [`BDSR_ADDR_W-1:0]  address,
    input  wire [`BDSR_DATA_W-1:0]  write_data_in,
    input  wire [`BDSR_LANES-1:0]   byte_lane_mask_n,
    output reg  [`BDSR_DATA_W-1:0]  read_data_out,
    output reg                      read_data_valid,
    output reg                      echo_strobe,
    output reg                      echo_strobe_n,
    output reg                      output_pair_mode
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function [3:0] word_index;
        input [`BDSR_IDX_W-1:0] idx;
        input [1:0]             beat;
        begin
            word_index = {idx, beat};
        end
    endfunction

    // Beat number within a burst, counted from the window's first half-cycle.
    function [1:0] beat_of;
        input [`BDSR_HALF_W-1:0] h;
        input [`BDSR_HALF_W-1:0] first;
        reg   [`BDSR_HALF_W-1:0] d;
        begin
            d       = h - first;
            beat_of = d[1:0];
        end
    endfunction

    function [`BDSR_HALF_W-1:0] inc_half;
        input [`BDSR_HALF_W-1:0] h;
        begin
            inc_half = h + 3'h1;
        end
    endfunction

    // A beat falls in a window of four half-cycles that opens at first.
    function in_window;
        input [`BDSR_HALF_W-1:0] h;
        input [`BDSR_HALF_W-1:0] first;
        begin
            in_window = (h >= first) && ((h - first) < 3'h4);
        end
    endfunction

    function [`BDSR_DATA_W-1:0] lane_merge;
        input [`BDSR_DATA_W-1:0] old_word;
        input [`BDSR_DATA_W-1:0] new_word;
        input [`BDSR_LANES-1:0]  mask_n;
        integer                  k;
        begin
            lane_merge = old_word;
            for (k = 0; k < `BDSR_LANES; k = k + 1) begin
                if (!mask_n[k]) begin
                    lane_merge[k*`BDSR_LANE_W +: `BDSR_LANE_W] =
                        new_word[k*`BDSR_LANE_W +: `BDSR_LANE_W];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    wire [`BDSR_SY_W-1:0] sy_in;
    wire [`BDSR_SY_W-1:0] sy;
    reg  [`BDSR_SY_W-1:0] sy_prev;

    assign sy_in = {byte_lane_mask_n, write_data_in, address, dll_bypass_n,
                    write_request_n, read_request_n, output_timing_neg,
                    output_timing_pos, cmd_strobe_neg, cmd_strobe_pos};

    bdsr_sync #(
        .W (`BDSR_SY_W)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (sy_in),
        .q       (sy)
    );

    // Inputs are taken from the stage before the strobe edge is seen, so
    // they meet setup against the strobe rather than relying on hold.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sy_prev <= {`BDSR_SY_W{1'b0}};
        end else begin
            sy_prev <= sy;
        end
    end

    wire                    cp_rise   = sy[`BDSR_SY_CP] & ~sy_prev[`BDSR_SY_CP];
    wire                    cn_rise   = sy[`BDSR_SY_CN] & ~sy_prev[`BDSR_SY_CN];
    wire                    op_rise   = sy[`BDSR_SY_OP] & ~sy_prev[`BDSR_SY_OP];
    wire                    on_rise   = sy[`BDSR_SY_ON] & ~sy_prev[`BDSR_SY_ON];
    wire                    rd_n      = sy_prev[`BDSR_SY_RD];
    wire                    wr_n      = sy_prev[`BDSR_SY_WR];
    wire                    byp_n     = sy_prev[`BDSR_SY_BYP];
    wire [`BDSR_IDX_W-1:0]  addr_idx  = sy_prev[`BDSR_SY_ADDR +: `BDSR_IDX_W];
    wire [`BDSR_DATA_W-1:0] beat_data = sy_prev[`BDSR_SY_DATA +: `BDSR_DATA_W];
    wire [`BDSR_LANES-1:0]  beat_mask = sy_prev[`BDSR_SY_MASK +: `BDSR_LANES];

    // ------------------------------------------------------------------
    // Output timing pair selection
    // ------------------------------------------------------------------
    // A pair that has shown no rising edge for the idle window is taken as
    // tied high. The window spans several link periods so a slow but live
    // pair is never mistaken for a tied one.
    reg [`BDSR_IDLE_W-1:0] ot_idle;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ot_idle          <= {`BDSR_IDLE_W{1'b0}};
            output_pair_mode <= 1'b0;
        end else if (op_rise | on_rise) begin
            ot_idle          <= {`BDSR_IDLE_W{1'b0}};
            output_pair_mode <= 1'b1;                                    // [RQ6]
        end else if (ot_idle == (`BDSR_OT_IDLE_CYC - 1)) begin
            output_pair_mode <= 1'b0;                                    // [RQ8]
        end else begin
            ot_idle <= ot_idle + {{(`BDSR_IDLE_W-1){1'b0}}, 1'b1};
        end
    end

    // Half-cycle ticks of whichever pair times the read outputs.
    wire rd_tick  = output_pair_mode ? (op_rise | on_rise) : (cp_rise | cn_rise); // [RQ6] [RQ8]
    wire wr_tick  = cp_rise | cn_rise;
    wire rd_take  = cp_rise & ~rd_n;                                     // [RQ1]
    wire wr_take  = cp_rise & ~wr_n;                                     // [RQ13]

    // Latency is 1.5 cycles with the DLL running, 1.0 when bypassed.
    wire [`BDSR_HALF_W-1:0] rd_first = byp_n ? `BDSR_FIRST_DLL : `BDSR_FIRST_BYP; // [RQ9] [RQ14]

    // ------------------------------------------------------------------
    // Storage and read and write burst slots
    // ------------------------------------------------------------------
    reg [`BDSR_DATA_W-1:0]  mem      [0:`BDSR_MEM_WORDS-1];
    reg                     rs_valid [0:`BDSR_SLOTS-1];
    reg [`BDSR_HALF_W-1:0]  rs_half  [0:`BDSR_SLOTS-1];
    reg [`BDSR_HALF_W-1:0]  rs_first [0:`BDSR_SLOTS-1];
    reg [`BDSR_WORDS_W-1:0] rs_words [0:`BDSR_SLOTS-1];
    reg                     ws_valid [0:`BDSR_SLOTS-1];
    reg [`BDSR_HALF_W-1:0]  ws_half  [0:`BDSR_SLOTS-1];
    reg [`BDSR_IDX_W-1:0]   ws_idx   [0:`BDSR_SLOTS-1];
    integer                 i;

    // Two slots cover back-to-back bursts: the next read is registered while
    // the last two beats of the previous one are still going out.
    wire rs_sel = rs_valid[0];
    wire ws_sel = ws_valid[0];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            for (i = 0; i < `BDSR_SLOTS; i = i + 1) begin
                rs_valid[i] <= 1'b0;
                rs_half[i]  <= {`BDSR_HALF_W{1'b0}};
                rs_first[i] <= `BDSR_FIRST_DLL;
                rs_words[i] <= {`BDSR_WORDS_W{1'b0}};
            end
            read_data_out   <= {`BDSR_DATA_W{1'b0}};
            read_data_valid <= 1'b0;
        end else begin
            if (rd_tick) begin
                read_data_valid <= 1'b0;
            end
            for (i = 0; i < `BDSR_SLOTS; i = i + 1) begin
                // A quiet request pin only advances a running burst. [RQ12]
                if (rs_valid[i] && rd_tick) begin
                    rs_half[i] <= inc_half(rs_half[i]);
                    if (in_window(inc_half(rs_half[i]), rs_first[i])) begin      // [RQ9] [RQ10] [RQ11]
                        read_data_out <= rs_words[i][(inc_half(rs_half[i]) - rs_first[i])
                                         * `BDSR_DATA_W +: `BDSR_DATA_W];
                        read_data_valid <= 1'b1;
                    end
                    if (inc_half(rs_half[i]) == rs_first[i] + 3'h3) begin
                        rs_valid[i] <= 1'b0;                             // [RQ4]
                    end
                end
            end
            // A request arriving with both slots busy breaks the every-other-cycle
            // spacing and is dropped. [RQ5]
            if (rd_take && !(rs_valid[0] && rs_valid[1])) begin
                rs_valid[rs_sel] <= 1'b1;                                // [RQ1]
                rs_half[rs_sel]  <= {`BDSR_HALF_W{1'b0}};
                rs_first[rs_sel] <= rd_first;                            // [RQ14]
                rs_words[rs_sel] <= {mem[word_index(addr_idx, 2'h3)],
                                     mem[word_index(addr_idx, 2'h2)],
                                     mem[word_index(addr_idx, 2'h1)],
                                     mem[word_index(addr_idx, 2'h0)]};   // [RQ4]
            end
        end
    end

    // ------------------------------------------------------------------
    // Echo strobes
    // ------------------------------------------------------------------
    // Registered on the same edge as the data so both leave together.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            echo_strobe   <= 1'b0;
            echo_strobe_n <= 1'b0;
        end else begin
            echo_strobe   <= output_pair_mode ? sy[`BDSR_SY_OP] : sy[`BDSR_SY_CP]; // [RQ7]
            echo_strobe_n <= output_pair_mode ? sy[`BDSR_SY_ON] : sy[`BDSR_SY_CN]; // [RQ7]
        end
    end

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    // Late write: beats follow on the four command strobe rises that start
    // one cycle after the write is registered.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            for (i = 0; i < `BDSR_SLOTS; i = i + 1) begin
                ws_valid[i] <= 1'b0;
                ws_half[i]  <= {`BDSR_HALF_W{1'b0}};
                ws_idx[i]   <= {`BDSR_IDX_W{1'b0}};
            end
        end else begin
            for (i = 0; i < `BDSR_SLOTS; i = i + 1) begin
                if (ws_valid[i] && wr_tick) begin
                    ws_half[i] <= inc_half(ws_half[i]);
                    if (inc_half(ws_half[i]) == `BDSR_WR_FIRST + 3'h3) begin
                        ws_valid[i] <= 1'b0;                             // [RQ4]
                    end
                end
            end
            if (wr_take && !(ws_valid[0] && ws_valid[1])) begin
                ws_valid[ws_sel] <= 1'b1;                                // [RQ13]
                ws_half[ws_sel]  <= {`BDSR_HALF_W{1'b0}};
                ws_idx[ws_sel]   <= addr_idx;
            end
        end
    end

    // Array storage holds no reset; contents are undefined until written.
    always @(posedge ref_clk) begin
        for (i = 0; i < `BDSR_SLOTS; i = i + 1) begin
            if (rst_n && ws_valid[i] && wr_tick &&
                in_window(inc_half(ws_half[i]), `BDSR_WR_FIRST)) begin
                // Mask and data come from the same strobe edge. [RQ3]
                mem[word_index(ws_idx[i], beat_of(inc_half(ws_half[i]), `BDSR_WR_FIRST))] <=
                    lane_merge(mem[word_index(ws_idx[i],
                                   beat_of(inc_half(ws_half[i]), `BDSR_WR_FIRST))],
                               beat_data, beat_mask);                    // [RQ2]
            end
        end
    end

endmodule // bdsr_read_port

`default_nettype wire

//--- inc/bdsr_map.vh
// Purpose: Constants shared by the burst-of-four DDR SRAM read port design.
// Assumes: Included by bare name; x18 organisation, two byte lanes of nine bits.
// Notes:   Definitions only.
`ifndef BDSR_MAP_VH
`define BDSR_MAP_VH

// ----------------------------------------------------------------------
// Widths and storage
// ----------------------------------------------------------------------
`define BDSR_DATA_W      18
`define BDSR_LANE_W      9
`define BDSR_LANES       2
`define BDSR_ADDR_W      18
`define BDSR_IDX_W       2
`define BDSR_MEM_WORDS   16
`define BDSR_BURST       4
`define BDSR_SLOTS       2
`define BDSR_HALF_W      3
`define BDSR_WORDS_W     72

// ----------------------------------------------------------------------
// Half-cycle positions of beats, counted from the registering edge
// ----------------------------------------------------------------------
`define BDSR_FIRST_DLL   3'h3
`define BDSR_FIRST_BYP   3'h2
`define BDSR_WR_FIRST    3'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BDSR_CLK_MHZ     100
`define BDSR_OT_IDLE_NS  400
`define BDSR_OT_IDLE_CYC ((`BDSR_OT_IDLE_NS * `BDSR_CLK_MHZ + 999) / 1000)
`define BDSR_IDLE_W      6

// ----------------------------------------------------------------------
// Field positions in the synchronised pin bus
// ----------------------------------------------------------------------
`define BDSR_SY_W        45
`define BDSR_SY_CP       0
`define BDSR_SY_CN       1
`define BDSR_SY_OP       2
`define BDSR_SY_ON       3
`define BDSR_SY_RD       4
`define BDSR_SY_WR       5
`define BDSR_SY_BYP      6
`define BDSR_SY_ADDR     7
`define BDSR_SY_DATA     25
`define BDSR_SY_MASK     43

`endif

//--- src/bdsr_sync.v
// Purpose: Two-flop synchroniser for a bus of pins entering the ref_clk domain.
// Assumes: Bits are independent levels; aligned use relies on slow link strobes.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none

module bdsr_sync #(
    parameter W = 1
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // bdsr_sync

`default_nettype wire

//--- sim/bdsr_port_checker.sv
// Purpose: Concurrent checks on the pins of the burst-of-four SRAM read port.
// Assumes: One ref_clk domain; link strobes are slow levels seen through synchronisers.
// Notes:   Bound to every instance of the port module.
`timescale 1ns/100ps
`default_nettype none
`include "bdsr_map.vh"

module bdsr_port_checker (
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    input wire logic                    cmd_strobe_pos,
    input wire logic                    cmd_strobe_neg,
    input wire logic                    output_timing_pos,
    input wire logic                    output_timing_neg,
    input wire logic                    read_request_n,
    input wire logic                    write_request_n,
    input wire logic                    dll_bypass_n,
    input wire logic [`BDSR_ADDR_W-1:0] address,
    input wire logic [`BDSR_DATA_W-1:0] write_data_in,
    input wire logic [`BDSR_LANES-1:0]  byte_lane_mask_n,
    input wire logic [`BDSR_DATA_W-1:0] read_data_out,
    input wire logic                    read_data_valid,
    input wire logic                    echo_strobe,
    input wire logic                    echo_strobe_n,
    input wire logic                    output_pair_mode
);
    // ------------------------------
    // Helper logic
    // ------------------------------
    // Counts cycles with the output pair held high; saturates so it never wraps.
    logic [6:0] hi_cnt;
    always @(posedge ref_clk) begin
        if (!rst_n || !(output_timing_pos && output_timing_neg)) begin
            hi_cnt <= 7'h00;
        end else if (hi_cnt != 7'h7F) begin
            hi_cnt <= hi_cnt + 7'h01;
        end
    end

    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_data_on_tick: assert property (!$stable(read_data_out) |-> !$stable(echo_strobe) || !$stable(echo_strobe_n))
        else $error("read data moved away from an echo edge");
    a_first_neg: assert property ($rose(read_data_valid) && !output_pair_mode && dll_bypass_n |-> $rose(echo_strobe_n))
        else $error("first command timed beat not on negative strobe");
    a_first_pos: assert property ($rose(read_data_valid) && !output_pair_mode && !dll_bypass_n |-> $rose(echo_strobe))
        else $error("first bypass beat not on positive strobe");
    a_burst_holds: assert property ($rose(read_data_valid) |-> read_data_valid [*8])
        else $error("burst cut short");
    a_valid_ends: assert property ($fell(read_data_valid) |-> !$stable(echo_strobe) || !$stable(echo_strobe_n))
        else $error("valid ended away from a tick");
    a_echo_runs: assert property (1'b1 |-> ##[1:60] !$stable(echo_strobe))
        else $error("echo strobe stopped");
    a_echo_n_runs: assert property (1'b1 |-> ##[1:60] !$stable(echo_strobe_n))
        else $error("negative echo strobe stopped");
    a_tied_mode: assert property (hi_cnt >= 7'h3C |-> !output_pair_mode)
        else $error("tied output pair still selected");
    a_pair_selects: assert property ($rose(output_timing_neg) && !output_timing_pos |-> ##[1:8] output_pair_mode)
        else $error("toggling output pair not selected");
endmodule // bdsr_port_checker

bind bdsr_read_port bdsr_port_checker i_chk (.ref_clk, .rst_n, .cmd_strobe_pos, .cmd_strobe_neg,
    .output_timing_pos, .output_timing_neg, .read_request_n, .write_request_n, .dll_bypass_n,
    .address, .write_data_in, .byte_lane_mask_n, .read_data_out, .read_data_valid, .echo_strobe,
    .echo_strobe_n, .output_pair_mode);
`default_nettype wire

//--- sim/bdsr_link_model.sv
// Purpose: Far-side strobe source: command strobe pair and output timing pair.
// Assumes: 125 ns strobe period; phases unrelated to ref_clk.
// Notes:   Commands and data are driven by the bench in step with these strobes.
`timescale 1ns/100ps
`default_nettype none

module bdsr_link_model (
    input  wire logic ot_run,
    output var  logic cmd_strobe_pos,
    output var  logic cmd_strobe_neg,
    output var  logic output_timing_pos,
    output var  logic output_timing_neg
);
    // The command pair runs free; both polarities switch so every half-tick has a rise.
    initial begin
        cmd_strobe_pos = 1'b0;
        cmd_strobe_neg = 1'b1;
        #3.3;
        forever begin
            #62.5;
            cmd_strobe_pos = ~cmd_strobe_pos;
            cmd_strobe_neg = ~cmd_strobe_pos;
        end
    end
    // The output pair toggles only while asked; otherwise both lines sit high.
    initial begin
        output_timing_pos = 1'b1;
        output_timing_neg = 1'b1;
        #21.7;
        forever begin
            #62.5;
            if (ot_run) begin
                output_timing_pos = ~output_timing_pos;
                output_timing_neg = ~output_timing_pos;
            end else begin
                output_timing_pos = 1'b1;
                output_timing_neg = 1'b1;
            end
        end
    end
endmodule // bdsr_link_model
`default_nettype wire

//--- sim/tb_burst4_ddr_sram_read_port.sv
// Purpose: Self-checking bench for the burst-of-four SRAM read port.
// Assumes: Partner strobes at 125 ns, ref_clk at 10 ns.
// Notes:   A per-half-tick schedule drives pins; a monitor pops expected beats.
`timescale 1ns/100ps
`default_nettype none

module tb_burst4_ddr_sram_read_port;
    typedef struct {logic [17:0] d; realtime t; bit tm;} bdsr_note_t;
    logic        ref_clk, rst_n, read_request_n, write_request_n, dll_bypass_n, ot_run;
    logic        cmd_strobe_pos, cmd_strobe_neg, output_timing_pos, output_timing_neg;
    logic        read_data_valid, echo_strobe, echo_strobe_n, output_pair_mode;
    logic [17:0] address, write_data_in, read_data_out, ad [0:63], wd [0:63], mem [0:15];
    logic [1:0]  byte_lane_mask_n, mk [0:63], ri [0:63];
    logic        rq_n [0:63], wq_n [0:63];
    bit          lp, ln, pe, pen, ok, cmdmode;
    integer      fails, num_checks, lat;
    bdsr_note_t  q [$];
    bdsr_note_t  nt;

    bdsr_link_model i_link (.ot_run, .cmd_strobe_pos, .cmd_strobe_neg, .output_timing_pos,
        .output_timing_neg);
    bdsr_read_port i_dut (.ref_clk, .rst_n, .cmd_strobe_pos, .cmd_strobe_neg, .output_timing_pos,
        .output_timing_neg, .read_request_n, .write_request_n, .dll_bypass_n, .address,
        .write_data_in, .byte_lane_mask_n, .read_data_out, .read_data_valid, .echo_strobe,
        .echo_strobe_n, .output_pair_mode);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------
    // Tasks
    // ------------------------------
    task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Idle data lines show a changing pattern so a late capture cannot pass by luck.
    task clr;
        for (int h = 0; h < 64; h++) begin
            rq_n[h] = 1'b1;
            wq_n[h] = 1'b1;
            ad[h] = 18'($urandom);
            wd[h] = (h == 0) ? 18'($urandom) : ~wd[h-1];
            mk[h] = 2'($urandom);
        end
    endtask

    task add_wr(input integer h, input logic [1:0] idx, input logic [7:0] m);
        wq_n[h] = 1'b0;
        ad[h][1:0] = idx;
        for (int b = 0; b < 4; b++) begin
            wd[h+2+b] = 18'($urandom);
            mk[h+2+b] = m[2*b +: 2];
            if (!m[2*b]) mem[{idx, 2'(b)}][8:0] = wd[h+2+b][8:0];
            if (!m[2*b+1]) mem[{idx, 2'(b)}][17:9] = wd[h+2+b][17:9];
        end
    endtask

    task add_rd(input integer h, input logic [1:0] idx);
        rq_n[h] = 1'b0;
        ad[h][1:0] = idx;
        ri[h] = idx;
    endtask

    task apply(input integer h);
        read_request_n <= rq_n[h];
        write_request_n <= wq_n[h];
        address <= ad[h];
        write_data_in <= wd[h];
        byte_lane_mask_n <= mk[h];
    endtask

    task wait_tick(output bit pos);
        bit got;
        got = 1'b0;
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge ref_clk);
            pos = cmd_strobe_pos && !lp;
            got = pos || (cmd_strobe_neg && !ln);
            lp = cmd_strobe_pos;
            ln = cmd_strobe_neg;
        end
        if (!got) begin
            fails++;
            conclude;
        end
    endtask

    // Values for half-tick h are set mid-way before its strobe rise and held past it.
    task run(input string name, input integer n);
        bit pos;
        @(posedge ref_clk);
        lp = cmd_strobe_pos;
        ln = cmd_strobe_neg;
        pos = 1'b1;
        while (pos) wait_tick(pos);
        repeat (3) @(posedge ref_clk);
        apply(0);
        for (int h = 0; h < n; h++) begin
            wait_tick(pos);
            for (int b = 0; b < 4 && !rq_n[h]; b++)
                q.push_back('{mem[{ri[h], 2'(b)}], $realtime + (lat + b) * 62.5, cmdmode});
            repeat (3) @(posedge ref_clk);
            apply(h + 1);
        end
        for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge ref_clk);
        chk("beats left", 18'h00000, 18'(q.size()));
        $display("test %s done", name);
    endtask

    // ------------------------------
    // Beat monitor
    // ------------------------------
    always @(negedge ref_clk) begin
        if (rst_n && read_data_valid === 1'b1 && ((echo_strobe && !pe) || (echo_strobe_n && !pen))) begin
            if (q.size() == 0) begin
                $display("ERROR beat expected none seen %h", read_data_out);
                fails++;
            end else begin
                nt = q.pop_front();
                chk("beat", nt.d, read_data_out);
                ok = ($realtime >= nt.t + 5) && ($realtime <= nt.t + 55);
                if (nt.tm) chk("beat time", 18'h00001, {17'h0, ok});
            end
        end
        pe = echo_strobe;
        pen = echo_strobe_n;
    end

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        {rst_n, dll_bypass_n, ot_run, read_request_n, write_request_n} = 5'b01011;
        address = 18'h00000;
        write_data_in = 18'h00000;
        byte_lane_mask_n = 2'h3;
        {fails, num_checks, lat, cmdmode} = {32'h0, 32'h0, 32'h3, 1'b1};
        void'($urandom(94593));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        clr;
        for (int i = 0; i < 4; i++) add_wr(4 * i, 2'(i), 8'h00);
        run("fill", 19);
        clr;
        add_wr(0, 2'h1, 8'hE4);
        for (int i = 0; i < 4; i++) add_rd(8 + 4 * i, 2'(i ^ 1));
        run("masked readback", 27);
        dll_bypass_n <= 1'b0;
        lat = 2;
        clr;
        add_rd(0, 2'h3);
        add_rd(4, 2'h1);
        run("bypass", 6);
        dll_bypass_n <= 1'b1;
        lat = 3;
        ot_run <= 1'b1;
        cmdmode = 1'b0;
        repeat (30) @(posedge ref_clk);
        chk("pair mode", 18'h00001, {17'h0, output_pair_mode});
        clr;
        add_rd(0, 2'h2);
        add_rd(4, 2'h0);
        run("pair timed", 6);
        ot_run <= 1'b0;
        cmdmode = 1'b1;
        repeat (60) @(posedge ref_clk);
        chk("cmd mode", 18'h00000, {17'h0, output_pair_mode});
        clr;
        add_rd(0, 2'h1);
        run("tied high", 2);
        conclude;
    end
endmodule // tb_burst4_ddr_sram_read_port
`default_nettype wire
